//--- hdl/banked_wave_memory.v
// eight-bank waveform store with multiplexed registered readout
`include "sequencer_defines.vh"
`timescale 1ns/10ps
module banked_wave_memory #(
   parameter ADDR_W = 12
) (
   input wire clk,
   input wire wr_en,
   input wire [ADDR_W-1:0] wr_addr,
   input wire [`SAMPLE_W-1:0] wr_data,
   input wire rd_en,
   input wire [ADDR_W-1:0] rd_addr,
   output reg [`SAMPLE_W-1:0] rd_data
);
   localparam ROW_W = ADDR_W - `BANK_BITS;
   localparam ROWS = 1 << ROW_W;
   reg [`SAMPLE_W-1:0] bank_mem [0:`NUM_BANKS*ROWS-1];
   reg [`SAMPLE_W-1:0] bank_q [0:`NUM_BANKS-1];
   reg [`BANK_BITS-1:0] bank_sel_r;
   integer b;

   // each bank reads its row in parallel; the selected one is muxed out
   always @(posedge clk) begin
      if (wr_en)
         bank_mem[{wr_addr[`BANK_BITS-1:0], wr_addr[ADDR_W-1:`BANK_BITS]}] <= wr_data;
      if (rd_en) begin
         for (b = 0; b < `NUM_BANKS; b = b + 1)
            bank_q[b] <= bank_mem[{b[`BANK_BITS-1:0], rd_addr[ADDR_W-1:`BANK_BITS]}];
         bank_sel_r <= rd_addr[`BANK_BITS-1:0];
      end
   end

   always @* begin
      rd_data = bank_q[bank_sel_r];
   end
endmodule // banked_wave_memory

//--- hdl/point_rate_divider.v
// point-rate enable generator with external source select and channel two divider
`timescale 1ns/10ps
module point_rate_divider #(
   parameter DIV_W = 32,
   parameter RATIO_W = 16
) (
   input wire clk,
   input wire resetn,
   input wire [DIV_W-1:0] int_period,
   input wire ext_clk_sel,
   input wire ext_clk_tick,
   input wire [RATIO_W-1:0] ch2_ratio,
   output wire pt_en_one,
   output wire pt_en_two
);
   reg [DIV_W-1:0] cnt_r;
   reg [RATIO_W-1:0] ch2_cnt_r;
   wire int_tick;
   wire src_tick;

   // period 0 or 1 means every clock; the synthesised rate tops out at clk here
   assign int_tick = (cnt_r == {DIV_W{1'b0}});
   assign src_tick = ext_clk_sel ? ext_clk_tick : int_tick;
   assign pt_en_one = src_tick;
   assign pt_en_two = src_tick && (ch2_cnt_r == {RATIO_W{1'b0}});

   always @(posedge clk) begin
      if (!resetn) begin
         cnt_r <= {DIV_W{1'b0}};
         ch2_cnt_r <= {RATIO_W{1'b0}};
      end else begin
         if (int_tick)
            cnt_r <= (int_period == {DIV_W{1'b0}}) ? {DIV_W{1'b0}} : int_period - {{(DIV_W-1){1'b0}}, 1'b1};
         else
            cnt_r <= cnt_r - {{(DIV_W-1){1'b0}}, 1'b1};
         if (src_tick) begin
            if (ch2_cnt_r == {RATIO_W{1'b0}})
               ch2_cnt_r <= (ch2_ratio == {RATIO_W{1'b0}}) ? {RATIO_W{1'b0}} :
                  ch2_ratio - {{(RATIO_W-1){1'b0}}, 1'b1};
            else
               ch2_cnt_r <= ch2_cnt_r - {{(RATIO_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // point_rate_divider

//--- hdl/sequencer_defines.vh
// constants for the waveform playback sequencer
`ifndef SEQUENCER_DEFINES_VH
`define SEQUENCER_DEFINES_VH

// operating modes, binary select code on mode_sel
`define MODE_CONT     3'h0
`define MODE_TRIG     3'h1
`define MODE_GATED    3'h2
`define MODE_BURST    3'h3
`define MODE_ADVANCE  3'h4
`define MODE_AUTOSTEP 3'h5

// sample word layout: 12 amplitude bits, two marker bits
`define SAMPLE_W      14
`define AMP_W         12
`define MARK_LSB      12
`define MARK_MSB      13

// eight banks, bank index in the low address bits
`define BANK_BITS     3
`define NUM_BANKS     8

// threshold: 0.1 V steps, -5.0 V to +5.0 V, code -50..50
`define LEVEL_STEP_MV 100
`define LEVEL_MIN     8'shce
`define LEVEL_MAX     8'sh32

// point clock limits
`define PT_MAX_HZ     250000000
`define PT_MIN_HZ     10
`define CLK_HZ        125000000

`endif

//--- hdl/waveform_playback_sequencer.v
// playback controller: modes, trigger/gate, sequence walk and sample readout
`include "sequencer_defines.vh"
`timescale 1ns/10ps
module waveform_playback_sequencer #(
   parameter ADDR_W = 12,
   parameter SEQ_W = 4,
   parameter REP_W = 16,
   parameter BURST_W = 16,
   parameter DIV_W = 32,
   parameter RATIO_W = 16,
   parameter PARAM_W = 32
) (
   input wire clk,
   input wire resetn,
   // configuration
   input wire [2:0] mode_sel,
   input wire run_start,
   input wire trig_slope_neg,
   input wire gate_pol_neg,
   input wire signed [7:0] level_code,
   input wire signed [7:0] ext_level_code,
   input wire ext_trig_in,
   input wire manual_trig,
   input wire [BURST_W-1:0] burst_count,
   input wire [DIV_W-1:0] int_period,
   input wire ext_clk_sel,
   input wire ext_clk_tick,
   input wire [RATIO_W-1:0] ch2_ratio,
   // sequence table load port
   input wire seq_wr_en,
   input wire [SEQ_W-1:0] seq_wr_idx,
   input wire [ADDR_W-1:0] seq_wr_start,
   input wire [ADDR_W-1:0] seq_wr_len,
   input wire [REP_W-1:0] seq_wr_rep,
   input wire [PARAM_W-1:0] seq_wr_param,
   input wire [SEQ_W-1:0] seq_last,
   // waveform memory load ports
   input wire mem1_wr_en,
   input wire mem2_wr_en,
   input wire [ADDR_W-1:0] mem_wr_addr,
   input wire [`SAMPLE_W-1:0] mem_wr_data,
   // outputs toward the converters
   output reg [`AMP_W-1:0] channel_one_sample,
   output reg [1:0] channel_one_marker,
   output reg [`AMP_W-1:0] channel_two_sample,
   output reg [1:0] channel_two_marker,
   output reg sample_valid,
   output reg [PARAM_W-1:0] step_param,
   output reg step_param_load,
   output wire running,
   output wire [SEQ_W-1:0] cur_entry,
   output wire gate_open,
   output wire signed [15:0] level_mv
);
   // ****************************************
   // states
   // ****************************************
   localparam ST_IDLE = 3'b001;
   localparam ST_PLAY = 3'b010;
   localparam ST_DONE = 3'b100;

   localparam SEQ_N = 1 << SEQ_W;

   reg [ADDR_W-1:0] seq_start [0:SEQ_N-1];
   reg [ADDR_W-1:0] seq_len [0:SEQ_N-1];
   reg [REP_W-1:0] seq_rep [0:SEQ_N-1];
   reg [PARAM_W-1:0] seq_param [0:SEQ_N-1];

   reg [2:0] state_r, state_nxt;
   reg [SEQ_W-1:0] entry_r;
   reg [ADDR_W-1:0] pos_r;
   reg [REP_W-1:0] rep_r;
   reg [BURST_W-1:0] burst_r;
   reg adv_pend_r;
   reg [2:0] mode_r;
   reg trig_s1_r, trig_s2_r, trig_s3_r;
   reg man_s1_r, man_s2_r, man_s3_r;
   reg gcmp_s1_r, gcmp_s2_r;
   reg rd_pending_r;
   reg rd2_pending_r;
   wire pt1, pt2;
   wire [`SAMPLE_W-1:0] q1, q2;

   // ****************************************
   // helpers
   // ****************************************
   function clamp_ok;
      input signed [7:0] c;
      begin
         clamp_ok = (c >= `LEVEL_MIN) && (c <= `LEVEL_MAX);
      end
   endfunction

   // next sequence entry, wrapping after the last one
   function [SEQ_W-1:0] next_entry;
      input [SEQ_W-1:0] e;
      input last;
      begin
         next_entry = last ? {SEQ_W{1'b0}} : e + {{(SEQ_W-1){1'b0}}, 1'b1};
      end
   endfunction

   // threshold clamped to the legal span; out-of-range codes pin to the limit
   wire signed [7:0] level_eff = clamp_ok(level_code) ? level_code :
      ((level_code < `LEVEL_MIN) ? `LEVEL_MIN : `LEVEL_MAX);
   assign level_mv = level_eff * $signed(16'd`LEVEL_STEP_MV);

   // ****************************************
   // input synchronisers and edge detect
   // ****************************************
   // comparator output is computed before the synchroniser, never after its first stage
   wire gate_cmp_raw = gate_pol_neg ? (ext_level_code < level_eff) : (ext_level_code > level_eff);
   always @(posedge clk) begin
      if (!resetn) begin
         trig_s1_r <= 1'b0;
         trig_s2_r <= 1'b0;
         trig_s3_r <= 1'b0;
         man_s1_r <= 1'b0;
         man_s2_r <= 1'b0;
         man_s3_r <= 1'b0;
         gcmp_s1_r <= 1'b0;
         gcmp_s2_r <= 1'b0;
      end else begin
         trig_s1_r <= ext_trig_in;
         trig_s2_r <= trig_s1_r;
         trig_s3_r <= trig_s2_r;
         man_s1_r <= manual_trig;
         man_s2_r <= man_s1_r;
         man_s3_r <= man_s2_r;
         gcmp_s1_r <= gate_cmp_raw;
         gcmp_s2_r <= gcmp_s1_r;
      end
   end

   wire ext_edge = trig_slope_neg ? (trig_s3_r && !trig_s2_r) : (!trig_s3_r && trig_s2_r);
   wire man_edge = man_s2_r && !man_s3_r;
   wire trig_evt = ext_edge || man_edge;
   assign gate_open = gcmp_s2_r || man_s2_r;

   // ****************************************
   // clocking and memories
   // ****************************************
   point_rate_divider #(.DIV_W(DIV_W), .RATIO_W(RATIO_W)) u_div (
      .clk(clk),
      .resetn(resetn),
      .int_period(int_period),
      .ext_clk_sel(ext_clk_sel),
      .ext_clk_tick(ext_clk_tick),
      .ch2_ratio(ch2_ratio),
      .pt_en_one(pt1),
      .pt_en_two(pt2)
   );

   wire [ADDR_W-1:0] rd_addr = seq_start[entry_r] + pos_r;
   wire play_now = (state_r == ST_PLAY) && ((mode_r != `MODE_GATED) || gate_open);
   wire step1 = play_now && pt1;
   wire step2 = play_now && pt2;

   banked_wave_memory #(.ADDR_W(ADDR_W)) u_mem1 (
      .clk(clk),
      .wr_en(mem1_wr_en),
      .wr_addr(mem_wr_addr),
      .wr_data(mem_wr_data),
      .rd_en(step1),
      .rd_addr(rd_addr),
      .rd_data(q1)
   );

   // channel two follows the same address stream at its divided rate
   banked_wave_memory #(.ADDR_W(ADDR_W)) u_mem2 (
      .clk(clk),
      .wr_en(mem2_wr_en),
      .wr_addr(mem_wr_addr),
      .wr_data(mem_wr_data),
      .rd_en(step2),
      .rd_addr(rd_addr),
      .rd_data(q2)
   );

   // ****************************************
   // sequence table
   // ****************************************
   always @(posedge clk) begin
      if (seq_wr_en) begin
         seq_start[seq_wr_idx] <= seq_wr_start;
         seq_len[seq_wr_idx] <= seq_wr_len;
         seq_rep[seq_wr_idx] <= seq_wr_rep;
         seq_param[seq_wr_idx] <= seq_wr_param;
      end
   end

   // ****************************************
   // playback state
   // ****************************************
   wire wave_end = step1 && (pos_r + {{(ADDR_W-1){1'b0}}, 1'b1} >= seq_len[entry_r]);
   wire last_rep = (rep_r <= {{(REP_W-1){1'b0}}, 1'b1});
   wire last_entry = (entry_r == seq_last);
   wire seq_end = wave_end && last_rep && last_entry;
   wire burst_last = (burst_r <= {{(BURST_W-1){1'b0}}, 1'b1});

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (mode_r == `MODE_CONT || mode_r == `MODE_GATED || mode_r == `MODE_ADVANCE)
               state_nxt = ST_PLAY;
            else if (trig_evt)
               state_nxt = ST_PLAY;
         end
         ST_PLAY: begin
            if ((mode_r == `MODE_TRIG) && seq_end)
               state_nxt = ST_IDLE;
            else if ((mode_r == `MODE_BURST) && seq_end && burst_last)
               state_nxt = ST_IDLE;
            else if ((mode_r == `MODE_AUTOSTEP) && wave_end && last_rep)
               state_nxt = last_entry ? ST_DONE : ST_IDLE;
         end
         ST_DONE: state_nxt = ST_DONE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge clk) begin
      if (!resetn) begin
         state_r <= ST_IDLE;
         mode_r <= `MODE_CONT;
         entry_r <= {SEQ_W{1'b0}};
         pos_r <= {ADDR_W{1'b0}};
         rep_r <= {REP_W{1'b0}};
         burst_r <= {BURST_W{1'b0}};
         adv_pend_r <= 1'b0;
         step_param <= {PARAM_W{1'b0}};
         step_param_load <= 1'b0;
      end else if (run_start) begin
         // software (re)selects the mode or step list: restart from entry zero
         state_r <= ST_IDLE;
         mode_r <= mode_sel;
         entry_r <= {SEQ_W{1'b0}};
         pos_r <= {ADDR_W{1'b0}};
         rep_r <= seq_rep[{SEQ_W{1'b0}}];
         adv_pend_r <= 1'b0;
         step_param_load <= 1'b0;
      end else begin
         state_r <= state_nxt;
         step_param_load <= 1'b0;
         if (state_r == ST_IDLE && state_nxt == ST_PLAY) begin
            // triggers start playback only here; a trigger while playing is dropped except in advance mode, where it sets adv_pend_r
            burst_r <= burst_count;
            pos_r <= {ADDR_W{1'b0}};
            rep_r <= seq_rep[entry_r];
            if (mode_r == `MODE_AUTOSTEP) begin
               step_param <= seq_param[entry_r];
               step_param_load <= 1'b1;
            end else if (mode_r != `MODE_ADVANCE) begin
               entry_r <= {SEQ_W{1'b0}};
               rep_r <= seq_rep[{SEQ_W{1'b0}}];
            end
         end
         if (mode_r == `MODE_ADVANCE && trig_evt && state_r == ST_PLAY)
            adv_pend_r <= 1'b1;
         if (step1) begin
            // gated halts simply freeze pos_r, so the next open gate resumes here
            if (!wave_end)
               pos_r <= pos_r + {{(ADDR_W-1){1'b0}}, 1'b1};
            else begin
               pos_r <= {ADDR_W{1'b0}};
               if (mode_r == `MODE_ADVANCE) begin
                  if (adv_pend_r || trig_evt) begin
                     adv_pend_r <= 1'b0;
                     entry_r <= next_entry(entry_r, last_entry);
                  end // else loop same entry, repeat count ignored
               end else if (mode_r == `MODE_AUTOSTEP) begin
                  if (!last_rep)
                     rep_r <= rep_r - {{(REP_W-1){1'b0}}, 1'b1};
                  else if (!last_entry)
                     entry_r <= entry_r + {{(SEQ_W-1){1'b0}}, 1'b1};
               end else if (!last_rep)
                  rep_r <= rep_r - {{(REP_W-1){1'b0}}, 1'b1};
               else begin
                  entry_r <= next_entry(entry_r, last_entry);
                  rep_r <= seq_rep[next_entry(entry_r, last_entry)];
                  if (last_entry && mode_r == `MODE_BURST && !burst_last)
                     burst_r <= burst_r - {{(BURST_W-1){1'b0}}, 1'b1};
               end
            end
         end
      end
   end

   assign running = play_now;
   assign cur_entry = entry_r;

   // ****************************************
   // sample output registers
   // ****************************************
   always @(posedge clk) begin
      if (!resetn) begin
         rd_pending_r <= 1'b0;
         rd2_pending_r <= 1'b0;
         sample_valid <= 1'b0;
         channel_one_sample <= {`AMP_W{1'b0}};
         channel_one_marker <= 2'h0;
         channel_two_sample <= {`AMP_W{1'b0}};
         channel_two_marker <= 2'h0;
      end else begin
         rd_pending_r <= step1;
         rd2_pending_r <= step2;
         sample_valid <= rd_pending_r;
         if (rd_pending_r) begin
            channel_one_sample <= q1[`AMP_W-1:0];
            channel_one_marker <= q1[`MARK_MSB:`MARK_LSB];
         end
         // channel two has its own fetch stage, so it updates at its divided rate
         if (rd2_pending_r) begin
            channel_two_sample <= q2[`AMP_W-1:0];
            channel_two_marker <= q2[`MARK_MSB:`MARK_LSB];
         end
      end
   end
endmodule // waveform_playback_sequencer

//--- testbench/dac_model.sv
// behavioural converter that takes in each channel one sample word
`timescale 1ns/10ps
module dac_model (
   input wire clk,
   input wire sample_valid,
   input wire [11:0] channel_one_sample,
   input wire [1:0] channel_one_marker
);
   // ****************
   // sample intake
   // ****************
   integer n = 0;
   reg [13:0] last_word = 14'h0000;
   // a word is only taken in a cycle where valid stands, one word for each such cycle
   always @(posedge clk) begin
      if (sample_valid === 1'b1) begin
         n <= n + 1;
         last_word <= {channel_one_marker, channel_one_sample};
      end
   end
endmodule // dac_model

//--- testbench/seq_monitor.sv
// concurrent checks on the playback sequencer ports
`include "sequencer_defines.vh"
`timescale 1ns/10ps
module seq_monitor #(
   parameter SEQ_W = 4,
   parameter DIV_W = 32
) (
   input wire clk,
   input wire resetn,
   input wire [2:0] mode_sel,
   input wire run_start,
   input wire [DIV_W-1:0] int_period,
   input wire ext_clk_sel,
   input wire ext_clk_tick,
   input wire signed [7:0] level_code,
   input wire sample_valid,
   input wire step_param_load,
   input wire running,
   input wire [SEQ_W-1:0] cur_entry,
   input wire gate_open,
   input wire signed [15:0] level_mv
);
   // ************************************
   // mode tracking and port relations
   // ************************************
   reg [2:0] mode_r;
   // rate checks only hold while the point tick fires every clock
   wire fast_w = !ext_clk_sel && int_period <= 1;
   always @(posedge clk) begin
      if (!resetn) mode_r <= `MODE_CONT;
      else if (run_start) mode_r <= mode_sel;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   chk_valid_cause: assert property (sample_valid |-> $past(running, 2))
      else $error("sample without a fetch two cycles before");
   chk_fetch_rate: assert property (running && fast_w && $past(fast_w) && !run_start |-> ##2 sample_valid)
      else $error("fetch gave no sample two cycles later");
   chk_ext_tick: assert property (sample_valid && ext_clk_sel && $past(ext_clk_sel, 3)
      |-> $past(ext_clk_tick, 2) || $past(ext_clk_tick, 3)) else $error("sample without external tick");
   chk_cont_run: assert property (mode_r == `MODE_CONT && fast_w && $past(fast_w) && $past(resetn)
      && !run_start && !$past(run_start) |-> running) else $error("continuous mode not playing");
   chk_gate_halt: assert property (mode_r == `MODE_GATED && !gate_open && !$past(run_start) |-> !running)
      else $error("gated output runs with gate closed");
   chk_level_scale: assert property (level_mv == (level_code > 8'sh32 ? 16'sh1388 :
      level_code < 8'shce ? 16'shec78 : level_code * 16'sh0064)) else $error("threshold scaling wrong");
   chk_param_pulse: assert property (step_param_load |-> mode_r == `MODE_AUTOSTEP ##1 !step_param_load)
      else $error("parameter load outside autostep or too long");
   chk_entry_step: assert property ($changed(cur_entry) && !$past(run_start)
      |-> cur_entry == $past(cur_entry) + 1'b1 || ~|cur_entry) else $error("entry jumped");
   chk_step_nowrap: assert property (mode_r == `MODE_AUTOSTEP && $changed(cur_entry) && !$past(run_start)
      |-> |cur_entry) else $error("step list wrapped");
endmodule // seq_monitor

//--- testbench/testbench.sv
// self-checking bench for the waveform playback sequencer
`include "sequencer_defines.vh"
`timescale 1ns/10ps
module testbench;
   reg clk = 1'b0;
   reg resetn = 1'b0;
   reg [2:0] mode_sel = 3'h0;
   reg run_start = 1'b0;
   reg trig_slope_neg = 1'b0;
   reg gate_pol_neg = 1'b0;
   reg signed [7:0] ext_level_code = 8'shf6;
   reg ext_trig_in = 1'b0;
   reg manual_trig = 1'b0;
   reg [31:0] int_period = 32'h0;
   reg ext_clk_sel = 1'b0;
   reg ext_clk_tick = 1'b0;
   reg seq_wr_en = 1'b0;
   reg [3:0] seq_wr_idx = 4'h0;
   reg [11:0] seq_wr_start = 12'h000;
   reg [15:0] seq_wr_rep = 16'h0000;
   reg [31:0] seq_wr_param = 32'h0;
   reg mem_wr_en = 1'b0;
   reg [11:0] mem_wr_addr = 12'h000;
   reg [13:0] mem_wr_data = 14'h0000;
   reg [31:0] plast = 32'h0;
   reg [13:0] l;
   reg [11:0] a;
   wire [11:0] ch1_sample;
   wire [1:0] ch1_marker;
   wire [11:0] ch2_sample;
   reg [11:0] ch2_last;
   integer ch2_n = 0;
   integer m0;
   wire sample_valid;
   wire step_param_load;
   wire running;
   wire gate_open;
   wire [31:0] step_param;
   wire [3:0] cur_entry;
   wire signed [15:0] level_mv;
   integer failures = 0;
   integer checks_done = 0;
   integer cycles = 0;
   integer loads = 0;
   integer n0;
   integer k;
   integer w;
   waveform_playback_sequencer dut (.clk(clk), .resetn(resetn), .mode_sel(mode_sel), .run_start(run_start),
      .trig_slope_neg(trig_slope_neg), .gate_pol_neg(gate_pol_neg), .level_code(8'sh05),
      .ext_level_code(ext_level_code), .ext_trig_in(ext_trig_in), .manual_trig(manual_trig),
      .burst_count(16'h0002), .int_period(int_period), .ext_clk_sel(ext_clk_sel), .ext_clk_tick(ext_clk_tick),
      .ch2_ratio(16'h0002), .seq_wr_en(seq_wr_en), .seq_wr_idx(seq_wr_idx), .seq_wr_start(seq_wr_start),
      .seq_wr_len(12'h004), .seq_wr_rep(seq_wr_rep), .seq_wr_param(seq_wr_param), .seq_last(4'h1),
      .mem1_wr_en(mem_wr_en), .mem2_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
      .channel_one_sample(ch1_sample), .channel_one_marker(ch1_marker), .channel_two_sample(ch2_sample),
      .channel_two_marker(), .sample_valid(sample_valid), .step_param(step_param),
      .step_param_load(step_param_load), .running(running), .cur_entry(cur_entry), .gate_open(gate_open),
      .level_mv(level_mv));
   dac_model dac (.clk(clk), .sample_valid(sample_valid), .channel_one_sample(ch1_sample),
      .channel_one_marker(ch1_marker));
   // ****************
   // access tasks
   // ****************
   initial begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (ch2_sample !== ch2_last) ch2_n <= ch2_n + 1;
      ch2_last <= ch2_sample;
      if (step_param_load === 1'b1) begin
         loads <= loads + 1;
         plast <= step_param;
      end
      if (cycles == 20000) begin
         failures = failures + 1;
         print_verdict;
      end
   end
   task tick(input integer c);
      begin
         repeat (c) @(posedge clk);
         #1;
      end
   endtask
   task check_eq(input [31:0] got, input [31:0] exp, input [8*12-1:0] what);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED at %0t: %0s got %0h expected %0h", $time, what, got, exp);
         end
      end
   endtask
   // rates are counted over a window, so one sample of slack either way
   task check_near(input [31:0] got, input [31:0] exp, input [8*12-1:0] what);
      check_eq((got > exp + 1 || got + 1 < exp) ? got : exp, exp, what);
   endtask
   task start(input [2:0] m);
      begin
         mode_sel = m;
         run_start = 1'b1;
         tick(1);
         run_start = 1'b0;
         tick(2);
      end
   endtask
   task trig(input ext);
      begin
         if (ext) ext_trig_in = ~trig_slope_neg;
         else manual_trig = 1'b1;
         tick(2);
         ext_trig_in = trig_slope_neg;
         manual_trig = 1'b0;
      end
   endtask
   task play(input ext, input again, input [31:0] exp);
      begin
         n0 = dac.n;
         trig(ext);
         tick(4);
         if (again) trig(1'b0);
         for (w = 0; w < 300 && running !== 1'b0; w = w + 1) tick(1);
         tick(3);
         check_eq(dac.n - n0, exp, "samples");
      end
   endtask
   task wr_seq(input [3:0] i, input [11:0] s, input [15:0] r, input [31:0] p);
      begin
         seq_wr_en = 1'b1;
         seq_wr_idx = i;
         seq_wr_start = s;
         seq_wr_rep = r;
         seq_wr_param = p;
         tick(1);
         seq_wr_en = 1'b0;
         tick(1);
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d failures %0d", checks_done, failures);
         if (failures == 0 && checks_done > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   initial begin
      tick(20);
      resetn = 1'b1;
      for (k = 0; k < 16; k = k + 1) begin
         mem_wr_en = 1'b1;
         mem_wr_addr = k[11:0];
         mem_wr_data = {k[1:0], k[11:0]};
         tick(1);
      end
      mem_wr_en = 1'b0;
      wr_seq(4'h0, 12'h000, 16'h0001, 32'h11);
      wr_seq(4'h1, 12'h008, 16'h0002, 32'h22);
      start(`MODE_CONT);
      n0 = dac.n;
      m0 = ch2_n;
      tick(60);
      check_eq(running, 1'b1, "running");
      check_near(dac.n - n0, 32'h3c, "rate");
      check_near(ch2_n - m0, 32'h1e, "ch2 rate");
      int_period = 32'h3;
      tick(3);
      n0 = dac.n;
      tick(60);
      check_near(dac.n - n0, 32'h14, "divided");
      int_period = 32'h0;
      ext_clk_sel = 1'b1;
      tick(3);
      n0 = dac.n;
      for (k = 0; k < 10; k = k + 1) begin
         ext_clk_tick = 1'b1;
         tick(1);
         ext_clk_tick = 1'b0;
         tick(3);
      end
      check_near(dac.n - n0, 32'ha, "ext ticks");
      ext_clk_sel = 1'b0;
      $display("test clocking done");
      start(`MODE_TRIG);
      play(1'b0, 1'b1, 32'h0c);
      play(1'b1, 1'b0, 32'h0c);
      trig_slope_neg = 1'b1;
      ext_trig_in = 1'b1;
      tick(8);
      check_eq(running, 1'b0, "rise ignored");
      play(1'b1, 1'b0, 32'h0c);
      trig_slope_neg = 1'b0;
      ext_trig_in = 1'b0;
      start(`MODE_BURST);
      play(1'b0, 1'b1, 32'h18);
      $display("test trigger done");
      start(`MODE_GATED);
      check_eq(running, 1'b0, "closed");
      ext_level_code = 8'sh14;
      tick(10);
      check_eq(running, 1'b1, "open");
      ext_level_code = 8'shf6;
      tick(8);
      l = dac.last_word;
      n0 = dac.n;
      tick(10);
      check_eq(dac.n - n0, 32'h0, "halted");
      manual_trig = 1'b1;
      for (w = 0; w < 50 && dac.n == n0; w = w + 1) tick(1);
      manual_trig = 1'b0;
      a = dac.last_word[11:0];
      check_eq(a == l[11:0] + 1 || l[11:0] == 12'h003 && a == 12'h008 || l[11:0] == 12'h00b && a[2:0] == 3'h0,
         1'b1, "resume");
      check_eq(dac.last_word[13:12], dac.last_word[1:0], "marker");
      for (k = 0; k < 4; k = k + 1) begin
         gate_pol_neg = k[1];
         ext_level_code = k[0] ? 8'sh14 : 8'shf6;
         tick(5);
         check_eq(gate_open, k[1] ^ k[0], "polarity");
      end
      gate_pol_neg = 1'b0;
      $display("test gated done");
      start(`MODE_ADVANCE);
      for (k = 0; k < 8; k = k + 1) begin
         tick(5);
         check_eq(cur_entry, 4'h0, "held");
      end
      trig(1'b0);
      tick(12);
      check_eq(cur_entry, 4'h1, "advanced");
      trig(1'b0);
      tick(12);
      check_eq(cur_entry, 4'h0, "wrapped");
      $display("test advance done");
      start(`MODE_AUTOSTEP);
      m0 = loads;
      play(1'b0, 1'b0, 32'h4);
      check_eq(plast, 32'h11, "param one");
      trig(1'b0);
      tick(20);
      check_eq(plast, 32'h22, "param two");
      play(1'b0, 1'b0, 32'h0);
      check_eq(loads - m0, 32'h2, "loads");
      start(`MODE_AUTOSTEP);
      play(1'b0, 1'b0, 32'h4);
      check_eq(plast, 32'h11, "param again");
      $display("test autostep done");
      print_verdict;
   end
endmodule // testbench
bind waveform_playback_sequencer seq_monitor #(.SEQ_W(SEQ_W), .DIV_W(DIV_W)) mon (.clk(clk), .resetn(resetn),
   .mode_sel(mode_sel), .run_start(run_start), .int_period(int_period), .ext_clk_sel(ext_clk_sel),
   .ext_clk_tick(ext_clk_tick), .level_code(level_code), .sample_valid(sample_valid),
   .step_param_load(step_param_load), .running(running), .cur_entry(cur_entry), .gate_open(gate_open),
   .level_mv(level_mv));
